// >>> rivm_map.svh
// reset and interrupt vector map: offsets, counts, encodings
// assumes word-addressed program memory and one word per vector
`ifndef RIVM_MAP_SVH
`define RIVM_MAP_SVH

// program counter width in words
`define RIVM_ADDR_W 13
// vector number width
`define RIVM_VNUM_W 5
// number of interrupt sources, vectors 2 to 26
`define RIVM_NUM_IRQ 25
// total vectors including reset
`define RIVM_NUM_VECTORS 26
// reset entry offset
`define RIVM_RESET_OFFSET 13'h0000
// offset of the first interrupt vector
`define RIVM_VEC_FIRST 13'h0001
// vector number of reset
`define RIVM_RESET_VNUM 5'h01
// vector number of the first interrupt
`define RIVM_IRQ_VNUM_FIRST 5'h02
// fuse level that means programmed
`define RIVM_FUSE_PROGRAMMED 1'b0

// per-source vector offsets from the section base, one word each
`define RIVM_OFF_EXTERNAL_REQUEST_ZERO 13'h001
`define RIVM_OFF_EXTERNAL_REQUEST_ONE 13'h002
`define RIVM_OFF_PIN_CHANGE_REQUEST_ZERO 13'h003
`define RIVM_OFF_PIN_CHANGE_REQUEST_ONE 13'h004
`define RIVM_OFF_PIN_CHANGE_REQUEST_TWO 13'h005
`define RIVM_OFF_WATCHDOG_TIMEOUT 13'h006
`define RIVM_OFF_TIMER_TWO_MATCH_A 13'h007
`define RIVM_OFF_TIMER_TWO_MATCH_B 13'h008
`define RIVM_OFF_TIMER_TWO_OVERFLOW 13'h009
`define RIVM_OFF_TIMER_ONE_CAPTURE 13'h00a
`define RIVM_OFF_TIMER_ONE_MATCH_A 13'h00b
`define RIVM_OFF_TIMER_ONE_MATCH_B 13'h00c
`define RIVM_OFF_TIMER_ONE_OVERFLOW 13'h00d
`define RIVM_OFF_TIMER_ZERO_MATCH_A 13'h00e
`define RIVM_OFF_TIMER_ZERO_MATCH_B 13'h00f
`define RIVM_OFF_TIMER_ZERO_OVERFLOW 13'h010
`define RIVM_OFF_SERIAL_TRANSFER_DONE 13'h011
`define RIVM_OFF_UART_RX_DONE 13'h012
`define RIVM_OFF_UART_TX_BUFFER_EMPTY 13'h013
`define RIVM_OFF_UART_TX_DONE 13'h014
`define RIVM_OFF_CONVERSION_DONE 13'h015
`define RIVM_OFF_NONVOLATILE_DATA_READY 13'h016
`define RIVM_OFF_ANALOG_COMPARE 13'h017
`define RIVM_OFF_TWO_WIRE_EVENT 13'h018
`define RIVM_OFF_SELF_PROGRAM_READY 13'h019

`endif

// >>> rivm_pkg.sv
// types for the reset and interrupt vector map
// assumes rivm_map.svh is on the include path
`include "rivm_map.svh"

package rivm_pkg;

  typedef logic [`RIVM_ADDR_W-1:0] rivm_addr_t;
  typedef logic [`RIVM_VNUM_W-1:0] rivm_vnum_t;
  typedef logic [`RIVM_NUM_IRQ-1:0] rivm_irq_t;

  // source bit positions, in vector order
  typedef enum logic [4:0] {
    SRC_EXTERNAL_REQUEST_ZERO = 5'h00,
    SRC_EXTERNAL_REQUEST_ONE = 5'h01,
    SRC_PIN_CHANGE_REQUEST_ZERO = 5'h02,
    SRC_PIN_CHANGE_REQUEST_ONE = 5'h03,
    SRC_PIN_CHANGE_REQUEST_TWO = 5'h04,
    SRC_WATCHDOG_TIMEOUT = 5'h05,
    SRC_TIMER_TWO_MATCH_A = 5'h06,
    SRC_TIMER_TWO_MATCH_B = 5'h07,
    SRC_TIMER_TWO_OVERFLOW = 5'h08,
    SRC_TIMER_ONE_CAPTURE = 5'h09,
    SRC_TIMER_ONE_MATCH_A = 5'h0a,
    SRC_TIMER_ONE_MATCH_B = 5'h0b,
    SRC_TIMER_ONE_OVERFLOW = 5'h0c,
    SRC_TIMER_ZERO_MATCH_A = 5'h0d,
    SRC_TIMER_ZERO_MATCH_B = 5'h0e,
    SRC_TIMER_ZERO_OVERFLOW = 5'h0f,
    SRC_SERIAL_TRANSFER_DONE = 5'h10,
    SRC_UART_RX_DONE = 5'h11,
    SRC_UART_TX_BUFFER_EMPTY = 5'h12,
    SRC_UART_TX_DONE = 5'h13,
    SRC_CONVERSION_DONE = 5'h14,
    SRC_NONVOLATILE_DATA_READY = 5'h15,
    SRC_ANALOG_COMPARE = 5'h16,
    SRC_TWO_WIRE_EVENT = 5'h17,
    SRC_SELF_PROGRAM_READY = 5'h18
  } rivm_src_e;

  typedef enum logic [2:0] {
    ST_BOOT = 3'b001,
    ST_IDLE = 3'b010,
    ST_TAKEN = 3'b100
  } rivm_state_e;

  // program counter load toward the core
  typedef struct packed {
    logic load;
    rivm_addr_t addr;
    rivm_vnum_t vnum;
  } rivm_fetch_s;

  // placement status
  typedef struct packed {
    rivm_addr_t reset_addr;
    rivm_addr_t vec_start;
    logic split;
  } rivm_place_s;

  typedef struct packed {
    rivm_state_e state;
    rivm_fetch_s fetch;
    rivm_irq_t ack;
    rivm_place_s place;
  } rivm_state_s;

endpackage

// >>> rivm_prio_enc.sv
// fixed priority picker: lowest bit wins
// assumes requests are stable within a cycle
`timescale 1ns/10ps
`default_nettype none
`include "rivm_map.svh"

module rivm_prio_enc
  import rivm_pkg::*;
(
  input wire rivm_irq_t req_i,
  output logic valid_o,
  output rivm_irq_t grant_o,
  output logic [4:0] index_o
);

  logic [`RIVM_NUM_IRQ:0] none_below;

  assign none_below[0] = 1'b1;

  // ------------------------------------------------------------
  // grant chain
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `RIVM_NUM_IRQ; gi = gi + 1) begin : g_chain
      assign none_below[gi+1] = none_below[gi] & ~req_i[gi];
      assign grant_o[gi] = req_i[gi] & none_below[gi];
    end
  endgenerate

  assign valid_o = ~none_below[`RIVM_NUM_IRQ];

  always_comb begin
    index_o = 5'h00;
    for (int i = 0; i < `RIVM_NUM_IRQ; i++) begin
      if (grant_o[i]) begin
        index_o = index_o | 5'(i);
      end
    end
  end

endmodule

`default_nettype wire

// >>> rivm_vector_map.sv
// reset and interrupt vector map: picks the entry address for the core
// assumes sources hold their request until acknowledged and clear it on ack
`timescale 1ns/10ps
`default_nettype none
`include "rivm_map.svh"

module rivm_vector_map
  import rivm_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic boot_reset_select_fuse_i,
  input wire logic vector_relocate_bit_i,
  input wire rivm_addr_t boot_reset_addr_i,
  input wire logic global_enable_i,
  input wire logic cpu_ready_i,
  input wire rivm_irq_t irq_req_i,
  input wire rivm_irq_t irq_enable_i,
  output rivm_fetch_s fetch_o,
  output rivm_irq_t irq_ack_o,
  output rivm_place_s place_o,
  output logic in_service_o
);

  // ------------------------------------------------------------
  // state and working signals
  // ------------------------------------------------------------
  rivm_state_s cur;
  rivm_state_s next_cur;

  rivm_irq_t pending;
  logic pick_valid;
  rivm_irq_t pick_grant;
  logic [4:0] pick_index;
  logic fuse_programmed;
  rivm_addr_t reset_addr;
  rivm_addr_t vec_base;
  rivm_addr_t vec_addr;
  rivm_addr_t vec_first;
  logic split_sections;
  rivm_addr_t src_offset;
  rivm_vnum_t src_vnum;
  logic src_known;
  logic take_ok;

  // ------------------------------------------------------------
  // placement
  // ------------------------------------------------------------
  assign fuse_programmed = (boot_reset_select_fuse_i == `RIVM_FUSE_PROGRAMMED);

  assign reset_addr = fuse_programmed ? boot_reset_addr_i : `RIVM_RESET_OFFSET;

  assign vec_base = vector_relocate_bit_i ? boot_reset_addr_i : `RIVM_RESET_OFFSET;

  // first vector entry of the selected section
  assign vec_first = rivm_addr_t'(vec_base + `RIVM_VEC_FIRST);

  // reset entry and vectors in different sections
  assign split_sections = fuse_programmed ^ vector_relocate_bit_i;

  // one word per vector, offset added to the section base
  assign vec_addr = rivm_addr_t'(vec_base + src_offset);

  // ------------------------------------------------------------
  // vector table, one entry per source
  // ------------------------------------------------------------
  always_comb begin
    src_offset = `RIVM_RESET_OFFSET;
    src_vnum = `RIVM_RESET_VNUM;
    src_known = 1'b0;
    unique case (rivm_src_e'(pick_index))
      SRC_EXTERNAL_REQUEST_ZERO: begin
        src_offset = `RIVM_OFF_EXTERNAL_REQUEST_ZERO;
        src_vnum = 5'h02;
        src_known = 1'b1;
      end
      SRC_EXTERNAL_REQUEST_ONE: begin
        src_offset = `RIVM_OFF_EXTERNAL_REQUEST_ONE;
        src_vnum = 5'h03;
        src_known = 1'b1;
      end
      SRC_PIN_CHANGE_REQUEST_ZERO: begin
        src_offset = `RIVM_OFF_PIN_CHANGE_REQUEST_ZERO;
        src_vnum = 5'h04;
        src_known = 1'b1;
      end
      SRC_PIN_CHANGE_REQUEST_ONE: begin
        src_offset = `RIVM_OFF_PIN_CHANGE_REQUEST_ONE;
        src_vnum = 5'h05;
        src_known = 1'b1;
      end
      SRC_PIN_CHANGE_REQUEST_TWO: begin
        src_offset = `RIVM_OFF_PIN_CHANGE_REQUEST_TWO;
        src_vnum = 5'h06;
        src_known = 1'b1;
      end
      SRC_WATCHDOG_TIMEOUT: begin
        src_offset = `RIVM_OFF_WATCHDOG_TIMEOUT;
        src_vnum = 5'h07;
        src_known = 1'b1;
      end
      SRC_TIMER_TWO_MATCH_A: begin
        src_offset = `RIVM_OFF_TIMER_TWO_MATCH_A;
        src_vnum = 5'h08;
        src_known = 1'b1;
      end
      SRC_TIMER_TWO_MATCH_B: begin
        src_offset = `RIVM_OFF_TIMER_TWO_MATCH_B;
        src_vnum = 5'h09;
        src_known = 1'b1;
      end
      SRC_TIMER_TWO_OVERFLOW: begin
        src_offset = `RIVM_OFF_TIMER_TWO_OVERFLOW;
        src_vnum = 5'h0a;
        src_known = 1'b1;
      end
      SRC_TIMER_ONE_CAPTURE: begin
        src_offset = `RIVM_OFF_TIMER_ONE_CAPTURE;
        src_vnum = 5'h0b;
        src_known = 1'b1;
      end
      SRC_TIMER_ONE_MATCH_A: begin
        src_offset = `RIVM_OFF_TIMER_ONE_MATCH_A;
        src_vnum = 5'h0c;
        src_known = 1'b1;
      end
      SRC_TIMER_ONE_MATCH_B: begin
        src_offset = `RIVM_OFF_TIMER_ONE_MATCH_B;
        src_vnum = 5'h0d;
        src_known = 1'b1;
      end
      SRC_TIMER_ONE_OVERFLOW: begin
        src_offset = `RIVM_OFF_TIMER_ONE_OVERFLOW;
        src_vnum = 5'h0e;
        src_known = 1'b1;
      end
      SRC_TIMER_ZERO_MATCH_A: begin
        src_offset = `RIVM_OFF_TIMER_ZERO_MATCH_A;
        src_vnum = 5'h0f;
        src_known = 1'b1;
      end
      SRC_TIMER_ZERO_MATCH_B: begin
        src_offset = `RIVM_OFF_TIMER_ZERO_MATCH_B;
        src_vnum = 5'h10;
        src_known = 1'b1;
      end
      SRC_TIMER_ZERO_OVERFLOW: begin
        src_offset = `RIVM_OFF_TIMER_ZERO_OVERFLOW;
        src_vnum = 5'h11;
        src_known = 1'b1;
      end
      SRC_SERIAL_TRANSFER_DONE: begin
        src_offset = `RIVM_OFF_SERIAL_TRANSFER_DONE;
        src_vnum = 5'h12;
        src_known = 1'b1;
      end
      SRC_UART_RX_DONE: begin
        src_offset = `RIVM_OFF_UART_RX_DONE;
        src_vnum = 5'h13;
        src_known = 1'b1;
      end
      SRC_UART_TX_BUFFER_EMPTY: begin
        src_offset = `RIVM_OFF_UART_TX_BUFFER_EMPTY;
        src_vnum = 5'h14;
        src_known = 1'b1;
      end
      SRC_UART_TX_DONE: begin
        src_offset = `RIVM_OFF_UART_TX_DONE;
        src_vnum = 5'h15;
        src_known = 1'b1;
      end
      SRC_CONVERSION_DONE: begin
        src_offset = `RIVM_OFF_CONVERSION_DONE;
        src_vnum = 5'h16;
        src_known = 1'b1;
      end
      SRC_NONVOLATILE_DATA_READY: begin
        src_offset = `RIVM_OFF_NONVOLATILE_DATA_READY;
        src_vnum = 5'h17;
        src_known = 1'b1;
      end
      SRC_ANALOG_COMPARE: begin
        src_offset = `RIVM_OFF_ANALOG_COMPARE;
        src_vnum = 5'h18;
        src_known = 1'b1;
      end
      SRC_TWO_WIRE_EVENT: begin
        src_offset = `RIVM_OFF_TWO_WIRE_EVENT;
        src_vnum = 5'h19;
        src_known = 1'b1;
      end
      SRC_SELF_PROGRAM_READY: begin
        src_offset = `RIVM_OFF_SELF_PROGRAM_READY;
        src_vnum = 5'h1a;
        src_known = 1'b1;
      end
      default: begin
        src_offset = `RIVM_RESET_OFFSET;
        src_vnum = `RIVM_RESET_VNUM;
        src_known = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // arbitration
  // ------------------------------------------------------------
  // per-source gating by its enable
  genvar gi;
  generate
    for (gi = 0; gi < `RIVM_NUM_IRQ; gi = gi + 1) begin : g_pend
      assign pending[gi] = irq_req_i[gi] & irq_enable_i[gi];
    end
  endgenerate

  rivm_prio_enc u_prio (
    .req_i(pending),
    .valid_o(pick_valid),
    .grant_o(pick_grant),
    .index_o(pick_index)
  );

  // taken only at an instruction boundary with a known source
  assign take_ok = global_enable_i && cpu_ready_i && pick_valid && src_known;

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    next_cur.fetch.load = 1'b0;
    next_cur.ack = '0;
    next_cur.place.reset_addr = reset_addr;
    next_cur.place.vec_start = vec_first;
    next_cur.place.split = split_sections;
    unique case (cur.state)
      ST_BOOT: begin
        // reset entry is fetched once, without waiting for the core
        next_cur.fetch.load = 1'b1;
        next_cur.fetch.addr = reset_addr;
        next_cur.fetch.vnum = `RIVM_RESET_VNUM;
        next_cur.state = ST_TAKEN;
      end
      ST_IDLE: begin
        // vectors are fetched only on a taken interrupt
        if (take_ok) begin
          next_cur.fetch.load = 1'b1;
          next_cur.fetch.addr = vec_addr;
          next_cur.fetch.vnum = src_vnum;
          next_cur.ack = pick_grant;
          next_cur.state = ST_TAKEN;
        end
      end
      ST_TAKEN: begin
        // one quiet cycle lets the acknowledged source drop its request
        next_cur.state = ST_IDLE;
      end
      default: begin
        next_cur.state = ST_BOOT;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      cur.state <= ST_BOOT;
      cur.fetch.load <= 1'b0;
      cur.fetch.addr <= '0;
      cur.fetch.vnum <= '0;
      cur.ack <= '0;
      cur.place.reset_addr <= '0;
      cur.place.vec_start <= '0;
      cur.place.split <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign fetch_o = cur.fetch;
  assign irq_ack_o = cur.ack;
  assign place_o = cur.place;
  assign in_service_o = (cur.state == ST_TAKEN);

endmodule

`default_nettype wire

// >>> rivm_vector_map_asserts.sv
// checker for the vector map
// assumes bind to rivm_vector_map
`timescale 1ns/10ps
`default_nettype none
module rivm_vector_map_asserts
  import rivm_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic boot_reset_select_fuse_i,
  input wire logic vector_relocate_bit_i,
  input wire rivm_addr_t boot_reset_addr_i,
  input wire logic global_enable_i,
  input wire logic cpu_ready_i,
  input wire rivm_irq_t irq_req_i,
  input wire rivm_irq_t irq_enable_i,
  input wire rivm_fetch_s fetch_o,
  input wire rivm_irq_t irq_ack_o,
  input wire logic in_service_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  // ----
  // checks
  // ----
  wire rivm_irq_t pend = irq_req_i & irq_enable_i;
  wire logic ack = |irq_ack_o;
  a_reset_fetch:
  assert property ($rose(rstn_i) |=> fetch_o == {1'b1, $past(boot_reset_select_fuse_i) ?
    13'h0 : $past(boot_reset_addr_i), 5'h01}) else $error("bad reset fetch");
  a_take_delay:
  assert property ($past(rstn_i) && !fetch_o.load && global_enable_i && cpu_ready_i && |pend
    |=> ack) else $error("late take");
  a_ack_cause:
  assert property (ack |-> fetch_o.load && |($past(pend) & irq_ack_o)) else $error("bad ack");
  a_lowest_wins:
  assert property (ack |-> ($past(pend) & (irq_ack_o - 25'h1)) == 25'h0) else $error("order");
  a_vector_num:
  assert property (ack |-> irq_ack_o == 25'h1 << (fetch_o.vnum - 5'h02)) else $error("vnum");
  a_vector_addr:
  assert property (ack |-> fetch_o.addr == ($past(vector_relocate_bit_i) ?
    $past(boot_reset_addr_i) : 13'h0) + 13'(fetch_o.vnum) - 13'h1) else $error("addr");
  a_load_pulse:
  assert property (fetch_o.load |=> !fetch_o.load) else $error("long load");
  a_service_flag:
  assert property (in_service_o == fetch_o.load) else $error("service flag");
endmodule
bind rivm_vector_map rivm_vector_map_asserts chk_u (.*);
`default_nettype wire

// >>> rivm_src_model.sv
// interrupt source model
// assumes post_i changes off the rising edge
`timescale 1ns/10ps
`default_nettype none
module rivm_src_model
  import rivm_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire rivm_irq_t post_i,
  input wire rivm_irq_t ack_i,
  output var rivm_irq_t req_o
);
  // ----
  // request stands until acked
  // ----
  always_ff @(posedge ref_clk_i) begin
    req_o <= rstn_i ? (req_o & ~ack_i) | post_i : 25'h0;
  end
endmodule
`default_nettype wire

// >>> rivm_vector_map_tb.sv
// testbench for the vector map
// assumes rivm_src_model as the sources
`timescale 1ns/10ps
`default_nettype none
module rivm_vector_map_tb
  import rivm_pkg::*;
;
  logic ref_clk_i = 1'b0, rstn_i = 1'b0, boot_reset_select_fuse_i = 1'b1;
  logic vector_relocate_bit_i = 1'b0, global_enable_i = 1'b1, cpu_ready_i = 1'b1;
  logic in_service_o;
  rivm_addr_t boot_reset_addr_i = 13'h0c00;
  rivm_irq_t irq_enable_i = '1, post = '0, irq_req_i, irq_ack_o;
  rivm_fetch_s fetch_o;
  rivm_place_s place_o;
  int error_cnt = 0, compares = 0;
  initial forever #20 ref_clk_i = ~ref_clk_i;
  rivm_vector_map dut_u (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .boot_reset_select_fuse_i(boot_reset_select_fuse_i),
    .vector_relocate_bit_i(vector_relocate_bit_i),
    .boot_reset_addr_i(boot_reset_addr_i),
    .global_enable_i(global_enable_i),
    .cpu_ready_i(cpu_ready_i),
    .irq_req_i(irq_req_i),
    .irq_enable_i(irq_enable_i),
    .fetch_o(fetch_o),
    .irq_ack_o(irq_ack_o),
    .place_o(place_o),
    .in_service_o(in_service_o)
  );
  rivm_src_model src_u (.ref_clk_i, .rstn_i, .post_i(post), .ack_i(irq_ack_o),
    .req_o(irq_req_i));
  // ----
  // tasks
  // ----
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %0t %h %h", $time, s, e);
    end
  endtask
  task automatic give_verdict;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wait_load;
    for (int n = 0; n < 8; n++) begin
      @(negedge ref_clk_i);
      if (fetch_o.load === 1'b1) return;
    end
    error_cnt++;
    give_verdict();
  endtask
  task automatic t_reset(input logic fu);
    rstn_i = 1'b0;
    boot_reset_select_fuse_i = fu;
    repeat (5) @(negedge ref_clk_i);
    rstn_i = 1'b1;
    wait_load();
    chk(fetch_o, {1'b1, fu ? 13'h0 : boot_reset_addr_i, 5'h01});
    chk(place_o, {fu ? 13'h0 : boot_reset_addr_i, 13'h1, ~fu});
    chk(in_service_o, 1'b1);
    $display("reset done");
  endtask
  task automatic t_each(input logic rl);
    logic [43:0] e;
    logic [26:0] p;
    vector_relocate_bit_i = rl;
    for (int k = 0; k < 25; k++) begin
      post = 25'h1 << k;
      @(negedge ref_clk_i);
      post = '0;
      wait_load();
      e = {1'b1, (rl ? boot_reset_addr_i : 13'h0) + 13'h1 + 13'(k), 5'h02 + 5'(k), 25'h1 << k};
      chk({fetch_o, irq_ack_o}, e);
      p = {boot_reset_select_fuse_i ? 13'h0 : boot_reset_addr_i,
        (rl ? boot_reset_addr_i : 13'h0) + 13'h1, ~boot_reset_select_fuse_i ^ rl};
      chk(place_o, p);
    end
    $display("sources done");
  endtask
  task automatic t_prio;
    global_enable_i = 1'b0;
    irq_enable_i = 25'h1fffffe;
    post = 25'h0100009;
    @(negedge ref_clk_i);
    post = '0;
    repeat (3) @(negedge ref_clk_i);
    chk(fetch_o.load, 1'b0);
    global_enable_i = 1'b1;
    cpu_ready_i = 1'b0;
    repeat (3) @(negedge ref_clk_i);
    chk(fetch_o.load, 1'b0);
    cpu_ready_i = 1'b1;
    wait_load();
    chk(irq_ack_o, 25'h8);
    repeat (2) @(negedge ref_clk_i);
    chk(irq_ack_o, 25'h100000);
    $display("priority done");
  endtask
  initial begin
    t_reset(1'b1);
    t_each(1'b0);
    t_reset(1'b0);
    t_each(1'b1);
    t_prio();
    give_verdict();
  end
endmodule
`default_nettype wire
